/* File: design/lpfc_consts.svh */
// Purpose: Offsets, field positions, reset values and counts of the stop/freeze/clock block.
// Assumes: Included by the design modules by bare name.
// Notes:   Definitions only.
`ifndef LPFC_CONSTS_SVH
`define LPFC_CONSTS_SVH
// Register byte offsets.
`define LPFC_OFS_CFG      8'h00
`define LPFC_OFS_SYNTH    8'h04
`define LPFC_OFS_TICK     8'h08
`define LPFC_OFS_SERVICE  8'h0c
`define LPFC_OFS_STATUS   8'h10
// Module configuration fields.
`define LPFC_CFG_KEEP     0
`define LPFC_CFG_FREEZE_BUS_WATCH_BIT    1
`define LPFC_CFG_FRZDT    2
`define LPFC_CFG_DOGEN    3
`define LPFC_CFG_RST      4'h0
// Synthesizer control fields.
`define LPFC_SYN_W        15
`define LPFC_SYN_X        14
`define LPFC_SYN_Y_LO     8
`define LPFC_SYN_RST      16'h3f00
// Tick timer fields.
`define LPFC_TCK_PRESC    8
`define LPFC_TCK_LVL_LO   12
// Service key pair.
`define LPFC_KEY_FIRST    8'h55
`define LPFC_KEY_SECOND   8'haa
// Tick prescaler and post divider.
`define LPFC_TCK_PRE_DIV  9'h1ff
`define LPFC_TCK_POST_DIV 2'h3
`endif

/* File: design/lpfc_pkg.sv */
// Purpose: Types shared by the stop/freeze/clock block and its tick timer.
// Assumes: Constants come from lpfc_consts.svh.
// Notes:   Holds types only.
package lpfc_pkg;
   // Stop sequencing states.
   typedef enum logic [1:0] {LPFC_RUN, LPFC_STOP, LPFC_WAKE} lpfc_state_e;
   // Tick timer setup as software wrote it.
   typedef struct packed {
      logic [2:0] level;
      logic       presc;
      logic [7:0] modulus;
   } lpfc_tick_cfg_s;
endpackage

/* File: design/lpfc_tick_timer.sv */
// Purpose: Periodic tick timer: prescaler, divide by four and modulus down counter.
// Assumes: ref_tick_i is a one-cycle enable at the reference rate.
// Notes:   A new nonzero modulus is taken when the running count completes; a zero modulus stops the timer at once.
`timescale 1ns/100ps
`include "lpfc_consts.svh"
module lpfc_tick_timer (
   // Clock and reset.
   input  wire logic                    clk_i,
   input  wire logic                    rst_i,
   // Setup and gating.
   input  wire lpfc_pkg::lpfc_tick_cfg_s cfg_i,
   input  wire logic                    run_i,
   input  wire logic                    ref_tick_i,
   // Expiry pulse.
   output logic                         fire_o
);
   import lpfc_pkg::*;

   logic [8:0] pre_r;
   logic [1:0] post_r;
   logic [7:0] cnt_r;
   logic       fire_r;

   // Prescale by 512 when selected, then always divide by four.
   wire pre_tick  = run_i && ref_tick_i &&
                    (!cfg_i.presc || pre_r == `LPFC_TCK_PRE_DIV);
   wire post_tick = pre_tick && post_r == `LPFC_TCK_POST_DIV;
   wire off       = cfg_i.modulus == 8'h00;
   wire done      = post_tick && !off && cnt_r == 8'h01;

   // Dividers and modulus counter only move while running.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pre_r  <= 9'h000;
         post_r <= 2'h0;
         cnt_r  <= 8'h00;
         fire_r <= 1'b0;
      end else begin
         fire_r <= done;
         if (run_i && ref_tick_i)
            pre_r <= pre_r + 9'h001;
         if (pre_tick)
            post_r <= post_r + 2'h1;
         if (post_tick) begin
            // A zero modulus holds the timer off; reload on completion.
            if (off)
               cnt_r <= 8'h00;
            else if (cnt_r == 8'h00 || cnt_r == 8'h01)
               cnt_r <= cfg_i.modulus;
            else
               cnt_r <= cnt_r - 8'h01;
         end
      end
   end

   assign fire_o = fire_r;
endmodule

/* File: design/lpfc_ctrl.sv */
// Purpose: Low-power stop, debug freeze gating and clock source control.
// Assumes: APB slave, zero wait states; inputs synchronous to clk_i.
// Notes:   Clock gates and synthesizer fields are outputs to the analog clock unit.
//
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/100ps
`include "lpfc_consts.svh"
// Notes on behaviour
// - Stop instruction latches the processor interrupt mask, then enters stop.
// - In stop, internal clocks gate off; the keep bit keeps only the unit clock running.
// - Bus, halt and spurious interrupt monitors are inactive in stop.
// - Watchdog holds its count in stop, resumes first edge after.
// - Stop never clears the watchdog; only the service pair or an expiry does.
// - Tick timer keeps counting and interrupting through stop.
// - Tick or external interrupt above latched mask ends stop.
// - Any reset ends stop.
// - Freeze touches only bus monitor, watchdog and tick timer.
// - Freeze with bus-watch freeze bit set disables the bus monitor.
// - Freeze with dog/tick freeze bit set suspends watchdog and tick timer.
// - Clock rate changes leave all register contents intact.
// - Strap high in reset enables synthesizer; control register sets it.
// - Strap low in reset disables synthesizer; its writes are ignored.
// - VCO runs at two or four times system clock per divide bit.
// - Divide bit clear at reset gives quarter VCO; set doubles, no relock.
// - Zero modulus turns tick timer off; else fire at zero and reload.
module lpfc_ctrl #(
   parameter int DOG_LIMIT = 32768
) (
   // Clock and reset.
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // APB slave.
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Processor side.
   input  wire logic        low_power_stop_instr_i,
   input  wire logic [2:0]  ipl_mask_i,
   input  wire logic        freeze_i,
   input  wire logic [2:0]  ext_irq_level_i,
   output logic             wake_irq_o,
   output logic [2:0]       wake_level_o,
   output logic             tick_irq_o,
   // Strap and reference.
   input  wire logic        clock_source_strap_i,
   input  wire logic        ref_tick_i,
   // Clock gates and monitor enables.
   output logic             stopped_o,
   output logic             unit_clk_en_o,
   output logic             periph_clk_en_o,
   output logic             bus_mon_en_o,
   output logic             halt_mon_en_o,
   output logic             spur_mon_en_o,
   output logic             dog_clk_en_o,
   output logic             dog_reset_o,
   // Synthesizer controls.
   output logic             synth_en_o,
   output logic             synth_w_o,
   output logic             synth_x_o,
   output logic [5:0]       synth_y_o,
   output logic             vco_ratio_four_o
);
   import lpfc_pkg::*;

   // Counter width covers the limit itself.
   localparam int DOG_W = $clog2(DOG_LIMIT + 1);

   // The watchdog counter must be able to reach its limit.
   if (DOG_LIMIT < 2) begin : g_bad_limit
      $error("DOG_LIMIT must be at least 2");
   end

   // Word decode of one register offset; shared by every register.
   function automatic logic ofs_hit(input logic [7:0] addr, input logic [7:0] ofs);
      return addr == ofs;
   endfunction

   // Priority test against the latched mask; a request must exceed it to count.
   function automatic logic above_mask(input logic [2:0] lvl, input logic [2:0] msk);
      return lvl > msk;
   endfunction

   // State, latched mask and software-visible registers.
   lpfc_state_e    state_r;
   lpfc_state_e    state_nxt;
   logic [2:0]     mask_r;
   logic [2:0]     wake_lvl_r;
   logic           wake_irq_r;
   logic [3:0]     cfg_r;
   logic           synth_en_r;
   logic [15:0]    synth_r;
   lpfc_tick_cfg_s tick_cfg_r;
   logic           key_armed_r;
   logic [DOG_W-1:0] dog_cnt_r;
   logic           dog_reset_r;
   logic [31:0]    prdata_r;
   logic           tick_fire;

   // APB decode. Only the access phase writes; the setup phase merely selects.
   // Read data is loaded at the setup edge so it stands for the access phase.
   wire acc      = psel && penable;
   wire wr       = acc && pwrite;
   wire hit_cfg  = ofs_hit(paddr, `LPFC_OFS_CFG);
   wire hit_syn  = ofs_hit(paddr, `LPFC_OFS_SYNTH);
   wire hit_tck  = ofs_hit(paddr, `LPFC_OFS_TICK);
   wire hit_svc  = ofs_hit(paddr, `LPFC_OFS_SERVICE);
   wire hit_sts  = ofs_hit(paddr, `LPFC_OFS_STATUS);
   wire mapped   = hit_cfg || hit_syn || hit_tck || hit_svc || hit_sts;
   wire wr_cfg   = wr && hit_cfg;
   wire wr_syn   = wr && hit_syn && synth_en_r;
   wire wr_tck   = wr && hit_tck;
   wire wr_svc   = wr && hit_svc;

   // Configuration bits.
   // Bits above the watchdog enable read back as zero.
   wire keep_bit   = cfg_r[`LPFC_CFG_KEEP];
   wire frz_bus    = cfg_r[`LPFC_CFG_FREEZE_BUS_WATCH_BIT];
   wire frz_dogtck = cfg_r[`LPFC_CFG_FRZDT];
   wire dog_en     = cfg_r[`LPFC_CFG_DOGEN];

   // Stop and freeze qualifiers.
   // Freeze is a level from the core and acts only while it stands.
   wire in_stop    = state_r == LPFC_STOP;
   wire clocks_off = state_r == LPFC_STOP;
   wire frz_b      = freeze_i && frz_bus;
   wire frz_d      = freeze_i && frz_dogtck;
   // Freeze only reaches bus monitor, watchdog and tick timer.
   assign bus_mon_en_o  = !in_stop && !frz_b;
   assign halt_mon_en_o = !in_stop;
   assign spur_mon_en_o = !in_stop;
   assign dog_clk_en_o  = !in_stop && !frz_d;
   // The tick timer ignores stop; only freeze can suspend it.
   wire tick_run   = !frz_d;

   // Clock gating: keep bit leaves the unit clock running in stop.
   // The peripheral clock has no keep option; only the unit clock has one.
   assign unit_clk_en_o   = !clocks_off || keep_bit;
   assign periph_clk_en_o = !clocks_off;
   assign stopped_o       = in_stop;

   // Wake qualification against the mask latched at stop entry.
   // A tick expiry of equal level wins over an external request.
   wire tick_wake = tick_fire && above_mask(tick_cfg_r.level, mask_r);
   wire ext_wake  = above_mask(ext_irq_level_i, mask_r);
   wire wake      = tick_wake || ext_wake;
   wire [2:0] wake_lvl_nxt = (tick_wake && tick_cfg_r.level >= ext_irq_level_i)
                             ? tick_cfg_r.level : ext_irq_level_i;

   // Stop sequencing: run, stop, then one wake cycle with clocks back on.
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         LPFC_RUN: begin
            if (low_power_stop_instr_i)
               state_nxt = LPFC_STOP;
         end
         LPFC_STOP: begin
            if (wake)
               state_nxt = LPFC_WAKE;
         end
         LPFC_WAKE: begin
            state_nxt = LPFC_RUN;
         end
         default: begin
            state_nxt = LPFC_RUN;
         end
      endcase
   end

   // State, mask latch and wake presentation.
   // The interrupt is shown only after the wake cycle has ungated the clocks.
   // Mask resets to all ones, so nothing can wake a part that never stopped.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_r    <= LPFC_RUN;
         mask_r     <= 3'h7;
         wake_lvl_r <= 3'h0;
         wake_irq_r <= 1'b0;
      end else begin
         state_r    <= state_nxt;
         wake_irq_r <= state_r == LPFC_WAKE;
         if (state_r == LPFC_RUN && low_power_stop_instr_i)
            mask_r <= ipl_mask_i;
         if (in_stop && wake)
            wake_lvl_r <= wake_lvl_nxt;
      end
   end

   assign wake_irq_o   = wake_irq_r;
   assign wake_level_o = wake_lvl_r;

   // Strap is caught while reset is held, so the last reset cycle decides.
   // The enable has no reset value of its own: it simply is the strap.
   always_ff @(posedge clk_i) begin
      if (rst_i)
         synth_en_r <= clock_source_strap_i;
   end

   // Software registers. Nothing here depends on the clock rate, so a
   // synthesizer change cannot disturb stored values.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg_r      <= `LPFC_CFG_RST;
         synth_r    <= `LPFC_SYN_RST;
         tick_cfg_r <= '0;
      end else begin
         if (wr_cfg)
            cfg_r <= pwdata[3:0];
         if (wr_syn)
            synth_r <= pwdata[15:0];
         if (wr_tck) begin
            tick_cfg_r.modulus <= pwdata[7:0];
            tick_cfg_r.presc   <= pwdata[`LPFC_TCK_PRESC];
            tick_cfg_r.level   <= pwdata[`LPFC_TCK_LVL_LO +: 3];
         end
      end
   end

   // Synthesizer outputs; a disabled synthesizer shows its reset fields.
   // Writes are refused while the strap selects an external clock.
   assign synth_en_o       = synth_en_r;
   assign synth_w_o        = synth_r[`LPFC_SYN_W];
   assign synth_x_o        = synth_r[`LPFC_SYN_X];
   assign synth_y_o        = synth_r[`LPFC_SYN_Y_LO +: 6];
   // Divide bit clear: VCO is four times the system clock, set: twice.
   assign vco_ratio_four_o = !synth_r[`LPFC_SYN_X];

   // Service pair: first key arms, second key restarts the count.
   // Any other write to the service offset disarms, so a stray write needs a fresh pair.
   // The arm flag survives stop, so a pair may straddle a stop.
   wire key1    = wr_svc && pwdata[7:0] == `LPFC_KEY_FIRST;
   wire key2    = wr_svc && pwdata[7:0] == `LPFC_KEY_SECOND;
   wire service = key2 && key_armed_r;

   // Watchdog counter: held while its clock is gated, cleared by service or on expiry.
   // The limit is a parameter so that a bench can use a short period.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         key_armed_r <= 1'b0;
         dog_cnt_r   <= '0;
         dog_reset_r <= 1'b0;
      end else begin
         if (wr_svc)
            key_armed_r <= key1;
         dog_reset_r <= 1'b0;
         if (service)
            dog_cnt_r <= '0;
         else if (dog_en && dog_clk_en_o) begin
            // Count moves only on enabled edges, so stop merely pauses it.
            if (dog_cnt_r == DOG_W'(DOG_LIMIT - 1)) begin
               dog_cnt_r   <= '0;
               dog_reset_r <= 1'b1;
            end else
               dog_cnt_r <= dog_cnt_r + DOG_W'(1);
         end
      end
   end

   assign dog_reset_o = dog_reset_r;

   // Tick timer runs on its own enable, independent of the stop state.
   // Only freeze halts it; software halts it with a zero modulus.
   lpfc_tick_timer u_tick (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .cfg_i      (tick_cfg_r),
      .run_i      (tick_run),
      .ref_tick_i (ref_tick_i),
      .fire_o     (tick_fire)
   );

   // A zero level leaves the tick expiry silent toward the core.
   assign tick_irq_o = tick_fire && tick_cfg_r.level != 3'h0;

   // Read mux. Unmapped reads return zero and raise pslverr instead.
   wire [31:0] rd_sts = {22'h0, dog_en, synth_en_r, mask_r, wake_lvl_r,
                         state_r == LPFC_WAKE, in_stop};
   // Tick image: level field, prescale bit and modulus.
   wire [31:0] rd_tck = {17'h0, tick_cfg_r.level, 3'h0,
                         tick_cfg_r.presc, tick_cfg_r.modulus};
   wire [31:0] rd_mux = hit_cfg ? {28'h0, cfg_r} :
                        hit_syn ? {16'h0, synth_r} :
                        hit_tck ? rd_tck :
                        hit_sts ? rd_sts : 32'h0;

   // Read data registered at the setup edge of a read.
   // A flop keeps it steady through the whole access phase.
   always_ff @(posedge clk_i) begin
      if (rst_i)
         prdata_r <= 32'h0;
      else if (psel && !penable && !pwrite)
         prdata_r <= rd_mux;
   end

   // Zero wait states: every register answers in its access phase.
   // Unmapped addresses answer with an error.
   assign pready  = 1'b1;
   assign pslverr = acc && !mapped;
   assign prdata  = prdata_r;
endmodule

/* File: tb/lpfc_props.sv */
// Purpose: Assertions on the stop, wake, freeze and clock source ports.
// Assumes: Bound to lpfc_ctrl.
// Notes:   A mask copy mirrors the latch taken at stop entry.
`timescale 1ns/100ps
module lpfc_props (
   // Clock and reset.
   input wire logic       clk_i,
   input wire logic       rst_i,
   // Core side.
   input wire logic       low_power_stop_instr_i,
   input wire logic [2:0] ipl_mask_i,
   input wire logic       freeze_i,
   input wire logic [2:0] ext_irq_level_i,
   input wire logic       wake_irq_o,
   input wire logic [2:0] wake_level_o,
   // Gates and clock source.
   input wire logic       clock_source_strap_i,
   input wire logic       stopped_o,
   input wire logic       periph_clk_en_o,
   input wire logic       bus_mon_en_o,
   input wire logic       halt_mon_en_o,
   input wire logic       spur_mon_en_o,
   input wire logic       dog_clk_en_o,
   input wire logic       synth_en_o,
   input wire logic       synth_x_o,
   input wire logic       vco_ratio_four_o
);
   logic [2:0] mask_r;
   logic       was_r;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // The wake cycle has stopped_o low too, so was_r keeps it from latching.
   always_ff @(posedge clk_i) begin
      was_r <= stopped_o;
      if (low_power_stop_instr_i && !stopped_o && !was_r) begin
         mask_r <= ipl_mask_i;
      end
   end
   chk_stop_take: assert property (
      low_power_stop_instr_i && !stopped_o && !was_r |=> stopped_o)
      else $error("Stop pulse not taken.");
   chk_stop_cause: assert property (
      $rose(stopped_o) |-> $past(low_power_stop_instr_i))
      else $error("Stop entered without a pulse.");
   chk_clock_gate: assert property (
      stopped_o |-> !periph_clk_en_o && !dog_clk_en_o)
      else $error("Clock left running in stop.");
   chk_mon_stop: assert property (
      stopped_o |-> !bus_mon_en_o && !halt_mon_en_o && !spur_mon_en_o)
      else $error("Monitor active in stop.");
   chk_mon_run: assert property (
      !stopped_o |-> halt_mon_en_o && spur_mon_en_o)
      else $error("Halt or spurious monitor off.");
   chk_freeze_only: assert property (
      !stopped_o && !freeze_i |-> bus_mon_en_o && dog_clk_en_o)
      else $error("Gate off without freeze.");
   chk_wake_ext: assert property (
      stopped_o && ext_irq_level_i > mask_r |=> !stopped_o ##1 wake_irq_o)
      else $error("Qualifying request did not wake.");
   chk_wake_order: assert property (
      $fell(stopped_o) |-> periph_clk_en_o && !wake_irq_o ##1 wake_irq_o)
      else $error("Wake pulse before clocks.");
   chk_wake_level: assert property (
      wake_irq_o |-> wake_level_o > mask_r)
      else $error("Wake level not above mask.");
   chk_vco_ratio: assert property (
      vco_ratio_four_o != synth_x_o)
      else $error("Ratio does not follow divide bit.");
   chk_synth_off: assert property (
      !synth_en_o |=> $stable(synth_x_o))
      else $error("Divide bit moved with synth off.");
   chk_strap_take: assert property (disable iff (1'b0)
      rst_i |=> synth_en_o == $past(clock_source_strap_i))
      else $error("Strap not taken in reset.");
   // Main scenarios.
   cov_stop: cover property ($rose(stopped_o));
   cov_wake: cover property (wake_irq_o);
   cov_freeze: cover property (freeze_i && !dog_clk_en_o);
endmodule
bind lpfc_ctrl lpfc_props i_props (.*);

/* File: tb/lpfc_core_model.sv */
// Purpose: Processor core model: stop instruction, freeze, request level.
// Assumes: Driven from the bench through its tasks.
// Notes:   Every change lands by NBA just after a rising edge.
`timescale 1ns/100ps
module lpfc_core_model (
   // Clock.
   input wire logic  clk_i,
   // Toward the block.
   output logic       stop_o,
   output logic [2:0] mask_o,
   output logic       freeze_o,
   output logic [2:0] irq_o
);
   // Idle core, everything masked.
   initial begin
      stop_o = 1'b0;
      mask_o = 3'h7;
      freeze_o = 1'b0;
      irq_o = 3'h0;
   end
   // One-cycle stop instruction carrying the current mask.
   task automatic stop(input logic [2:0] m);
      @(posedge clk_i);
      stop_o <= 1'b1;
      mask_o <= m;
      @(posedge clk_i);
      stop_o <= 1'b0;
   endtask
   // Breakpoint freeze; held one tick period (eight cycles) at least so counts stay exact.
   task automatic bkpt(input int n);
      if (n < 8) n = 8;
      @(posedge clk_i);
      freeze_o <= 1'b1;
      repeat (n) @(posedge clk_i);
      freeze_o <= 1'b0;
   endtask
   // External request level.
   task automatic irq(input logic [2:0] l);
      @(posedge clk_i);
      irq_o <= l;
   endtask
endmodule

/* File: tb/low_power_freeze_clock_mode_ctrl_tb.sv */
// Purpose: Self-checking bench for lpfc_ctrl.
// Assumes: Watchdog shortened to 16 cycles; reference tick every cycle outside the ref_gate check.
// Notes:   Drive just after rising edges, sample on falling edges.
`timescale 1ns/100ps
module low_power_freeze_clock_mode_ctrl_tb;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic        strap = 1'b1;
   logic        stp, frz, wake, tirq, stopd, uclk, pclk, bmon, hmon, dclk, dres;
   logic        sen, sx, v4, pready, pslverr, se, smon, sw;
   logic        tck = 1'b1;
   logic [5:0]  sy;
   logic [2:0]  msk, irq, wlvl;
   logic [31:0] prdata, rd;
   int          num_errors = 0;
   int          checked = 0;
   int          cyc = 0;
   int          k;
   lpfc_core_model i_core (.clk_i(clk_i), .stop_o(stp), .mask_o(msk), .freeze_o(frz),
      .irq_o(irq));
   lpfc_ctrl #(.DOG_LIMIT(16)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .low_power_stop_instr_i(stp),
      .ipl_mask_i(msk), .freeze_i(frz), .ext_irq_level_i(irq), .wake_irq_o(wake),
      .wake_level_o(wlvl), .tick_irq_o(tirq), .clock_source_strap_i(strap),
      .ref_tick_i(tck), .stopped_o(stopd), .unit_clk_en_o(uclk), .periph_clk_en_o(pclk),
      .bus_mon_en_o(bmon), .halt_mon_en_o(hmon), .spur_mon_en_o(smon), .dog_clk_en_o(dclk),
      .dog_reset_o(dres), .synth_en_o(sen), .synth_w_o(sw), .synth_x_o(sx), .synth_y_o(sy),
      .vco_ratio_four_o(v4));
   // Clock and a hang limit well above the whole sequence.
   always #12.5 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         num_errors++;
         results();
      end
   end
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask
   // APB transfer; held until pready is seen high at an edge.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_i);
      penable <= 1'b1;
      do @(posedge clk_i); while (pready !== 1'b1);
      rd = prdata;
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rst(input logic s);
      @(posedge clk_i);
      rst_i <= 1'b1;
      strap <= s;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
   endtask
   // Count the cycles with one output high over n cycles, or wait for it with a bound.
   task automatic cnt(ref logic s, input int n);
      k = 0;
      repeat (n) begin
         @(negedge clk_i);
         k += int'(s === 1'b1);
      end
   endtask
   task automatic wt(ref logic s);
      for (int n = 0; n < 40 && s !== 1'b1; n++) @(negedge clk_i);
   endtask
   task automatic t_synth;
      @(negedge clk_i);
      chk("synth_en", sen, 1'b1);
      apb(1'b0, 8'h04, 32'h0);
      chk("synth_rst", rd, 32'h3f00);
      apb(1'b1, 8'h08, 32'h5002);
      apb(1'b1, 8'h04, 32'hc500);
      @(negedge clk_i);
      chk("ratio", {sx, v4}, 2'h2);
      chk("synth_wy", {sw, sy}, 7'h45);
      apb(1'b0, 8'h08, 32'h0);
      chk("tick_keep", rd[14:0], 15'h5002);
      apb(1'b0, 8'h14, 32'h0);
      chk("unmapped", se, 1'b1);
      rst(1'b0);
      apb(1'b1, 8'h04, 32'h4000);
      @(negedge clk_i);
      chk("synth_off", {sen, sx, sw, sy}, 9'h03f);
   endtask
   task automatic t_stop;
      apb(1'b1, 8'h08, 32'h0);
      i_core.stop(3'h3);
      @(negedge clk_i);
      chk("gates", {stopd, uclk, pclk, bmon, hmon, smon}, 6'h20);
      i_core.irq(3'h3);
      cnt(stopd, 4);
      chk("low_irq", k, 4);
      i_core.irq(3'h4);
      wt(wake);
      chk("wake", {wake, wlvl, uclk}, 5'h19);
      i_core.irq(3'h0);
      apb(1'b0, 8'h10, 32'h0);
      chk("status", rd, 32'h70);
      apb(1'b1, 8'h00, 32'h1);
      i_core.stop(3'h7);
      @(negedge clk_i);
      chk("keep", {stopd, uclk, pclk}, 3'h6);
      rst(1'b1);
      @(negedge clk_i);
      chk("rst_ends", stopd, 1'b0);
   endtask
   task automatic t_tick;
      apb(1'b1, 8'h08, 32'h5002);
      i_core.stop(3'h6);
      cnt(tirq, 40);
      chk("tick_stop", k >= 4 && stopd, 1'b1);
      i_core.irq(3'h7);
      wt(wake);
      i_core.irq(3'h0);
      i_core.stop(3'h4);
      wt(wake);
      chk("tick_wake", {wake, wlvl}, 4'hd);
      // With the reference enable low the timer must not advance.
      @(posedge clk_i);
      tck <= 1'b0;
      @(negedge clk_i);
      cnt(tirq, 40);
      chk("ref_gate", k, 0);
      @(posedge clk_i);
      tck <= 1'b1;
      apb(1'b1, 8'h08, 32'h5000);
      // Skip the cycle whose expiry may predate the write.
      @(negedge clk_i);
      cnt(tirq, 40);
      chk("tick_off", k, 0);
   endtask
   task automatic t_freeze;
      apb(1'b1, 8'h08, 32'h5002);
      apb(1'b1, 8'h00, 32'h6);
      fork
         i_core.bkpt(30);
         begin
            repeat (4) @(negedge clk_i);
            chk("frz", {bmon, dclk, hmon}, 3'h1);
            cnt(tirq, 20);
            chk("frz_tick", k <= 1, 1'b1);
         end
      join
   endtask
   task automatic t_dog;
      apb(1'b1, 8'h08, 32'h0);
      apb(1'b1, 8'h00, 32'h8);
      apb(1'b1, 8'h0c, 32'h55);
      apb(1'b1, 8'h0c, 32'haa);
      repeat (6) @(posedge clk_i);
      i_core.stop(3'h6);
      cnt(dres, 24);
      chk("dog_hold", k, 0);
      i_core.irq(3'h7);
      wt(wake);
      i_core.irq(3'h0);
      cnt(dres, 12);
      chk("dog_keep", k, 1);
   endtask
   task automatic results;
      $display("comparisons %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // Main sequence after a three-cycle reset.
   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      t_synth();
      t_stop();
      t_tick();
      t_freeze();
      t_dog();
      results();
   end
endmodule
